// *** hdl/eoc_maint_regs.vh ***
// Constants for the EOC and maintenance-bit processor.
// Assumes a frame strobe per received EOC word and per superframe.
// What this block does
// R01: Auto mode echoes each addressed EOC word that it can comply with in the next outgoing frame.
// R02: Auto mode answers foreign addresses with hold addressed to the NT.
// R03: Auto sends unable-to-comply on the third and each later addressed data word in a row, or on an undefined command.
// R04: Auto latches commands in parallel until return-to-normal or link down.
// R05: Auto mode interrupts on each triple-checked new word, any address.
// R06: Triple check needs three equal words unlike the last passed one.
// R07: Auto executes defined, addressed, triple-checked message commands.
// R08: Transparent modes never echo, latch or execute; send software word.
// R09: Every-frame transparent mode reports every received word each frame.
// R10: Software must write the next transmit word within two milliseconds.
// R11: In transparent modes software verifies, answers and executes commands.
// R12: On-change transparent mode reports only words unlike the previous.
// R13: Triple-check transparent mode reports words seen three times in a row.
// R14: Each M4 bit has its own filter, reported only once approved.
// R15: Checksum covers M4 bits but not the M5 and M6 spare bits.
// R16: State machine bits use triple check or optionally the software filter.
// R17: Before activation activation is 0, deactivation 1, NT-only 0.
// R18: Spare bits default to checksum-clean; else M4 filter or on-change.
// R19: Spare bits transmit as ones unless software wrote other values.
// R20: An EOC word is three address bits, one indicator bit, eight info bits.
// R21: Return-to-normal releases latched commands, sets transmit word FF unless software writes it in the same cycle.
`ifndef EOC_MAINT_REGS_VH
`define EOC_MAINT_REGS_VH
`define EOC_W 12
`define EOC_ADDR_HI 11
`define EOC_ADDR_LO 9
`define EOC_DM_BIT 8
`define ADDR_NT 3'h0
`define ADDR_BCAST 3'h7
`define MODE_AUTO 2'h0
`define MODE_EVERY 2'h1
`define MODE_CHANGE 2'h2
`define MODE_TRIPLE 2'h3
`define FILT_CHANGE 2'h0
`define FILT_TRIPLE 2'h1
`define FILT_CRC 2'h2
`define FILT_CRC_TRIPLE 2'h3
`define SPARE_CRC 2'h0
`define SPARE_M4 2'h1
`define SPARE_CHANGE 2'h2
`define CMD_HOLD 8'h00
`define CMD_LOOP_ALL 8'h50
`define CMD_LOOP_B1 8'h51
`define CMD_LOOP_B2 8'h52
`define CMD_CORRUPT 8'h53
`define CMD_NOTIFY 8'h54
`define CMD_UTC 8'hAA
`define CMD_RTN 8'hFF
`define EOC_TX_RESET 12'h0FF
`define LATCH_W 5
`define M4_W 8
`define M4_RESET 8'h02
`define SPARE_W 3
`define SPARE_RESET 3'h7
`endif

// *** hdl/word_buffer.v ***
// Two-entry buffer with valid/ready on both sides.
// Assumes source and sink on i_clk.
`timescale 1ns/1ps
module word_buffer #(
  parameter W = 12
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_reg [0:1];
  reg rd_reg;
  reg wr_reg;
  reg [1:0] cnt_reg;
  wire push;
  wire pop;
  assign o_in_ready = (cnt_reg != 2'h2);
  assign o_out_valid = (cnt_reg != 2'h0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mem_reg[0] <= {W{1'b0}};
      mem_reg[1] <= {W{1'b0}};
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_reg] <= i_in_data;
        wr_reg <= ~wr_reg;
      end
      if (pop)
        rd_reg <= ~rd_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule

// *** hdl/eoc_maintenance_bit_processor.v ***
// EOC processor and M4/M5/M6 report filters for the NT end.
// Assumes frame strobes and received fields come from framing logic on i_clk.
`timescale 1ns/1ps
`include "eoc_maint_regs.vh"
module eoc_maintenance_bit_processor #(
  parameter M4_W = `M4_W
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [1:0] i_eoc_mode,
  input wire [2*M4_W-1:0] i_m4_filter_sel,
  input wire i_sm_same_filter,
  input wire [1:0] i_spare_filter_sel,
  input wire i_eoc_rx_strobe,
  input wire [`EOC_W-1:0] i_eoc_rx_word,
  input wire i_sf_strobe,
  input wire i_crc_ok,
  input wire [M4_W-1:0] i_m4_rx,
  input wire [`SPARE_W-1:0] i_spare_rx,
  input wire i_deactivate,
  input wire i_eoc_tx_write,
  input wire [`EOC_W-1:0] i_eoc_tx_data,
  input wire i_spare_tx_write,
  input wire [`SPARE_W-1:0] i_spare_tx_data,
  input wire i_tx_ready,
  output wire o_tx_valid,
  output wire [`EOC_W-1:0] o_tx_word,
  output wire o_eoc_tx_full,
  output reg [`EOC_W-1:0] o_eoc_report,
  output reg o_eoc_irq,
  output reg [`LATCH_W-1:0] o_latched_cmds,
  output reg [M4_W-1:0] o_m4_report,
  output reg o_m4_irq,
  output reg [2:0] o_sm_bits,
  output reg [`SPARE_W-1:0] o_spare_report,
  output reg o_spare_irq,
  output reg [`SPARE_W-1:0] o_spare_tx
);
  // ==========================================================
  // EOC receive history
  // ==========================================================
  reg [`EOC_W-1:0] last_rx_reg;
  reg [`EOC_W-1:0] verified_reg;
  reg [1:0] same_cnt_reg;
  reg [1:0] data_cnt_reg;
  reg [`EOC_W-1:0] eoc_tx_reg;
  reg [`EOC_W-1:0] tx_next;
  reg tx_push;
  wire buf_ready;
  wire [2:0] rx_addr;
  wire rx_dm;
  wire [7:0] rx_info;
  wire addr_ok;
  wire defined;
  wire [1:0] cnt_next;
  wire triple_ok;
  wire changed;
  wire auto_mode;

  function is_defined;
    input [7:0] info;
    begin
      is_defined = (info == `CMD_HOLD) || (info == `CMD_LOOP_ALL) ||
        (info == `CMD_LOOP_B1) || (info == `CMD_LOOP_B2) ||
        (info == `CMD_CORRUPT) || (info == `CMD_NOTIFY) ||
        (info == `CMD_RTN);
    end
  endfunction

  assign rx_addr = i_eoc_rx_word[`EOC_ADDR_HI:`EOC_ADDR_LO]; // R20
  assign rx_dm = i_eoc_rx_word[`EOC_DM_BIT];
  assign rx_info = i_eoc_rx_word[7:0];
  assign addr_ok = (rx_addr == `ADDR_NT) || (rx_addr == `ADDR_BCAST);
  assign defined = is_defined(rx_info);
  assign auto_mode = (i_eoc_mode == `MODE_AUTO);
  assign changed = (i_eoc_rx_word != last_rx_reg);
  // Saturate so a long run of one word still counts as three
  assign cnt_next = changed ? 2'h1 :
    ((same_cnt_reg == 2'h3) ? 2'h3 : same_cnt_reg + 2'h1);
  assign triple_ok = (cnt_next == 2'h3) &&
    (i_eoc_rx_word != verified_reg); // R06

  // Word chosen for the next outgoing frame
  always @*
  begin
    tx_next = eoc_tx_reg; // R08
    tx_push = 1'b0;
    if (i_eoc_rx_strobe)
    begin
      tx_push = 1'b1;
      if (auto_mode)
      begin
        if (!addr_ok)
          tx_next = {`ADDR_NT, 1'b1, `CMD_HOLD}; // R02
        else if ((!rx_dm && data_cnt_reg == 2'h2) ||
          (rx_dm && !defined) ||
          (!rx_dm && data_cnt_reg == 2'h3))
          tx_next = {rx_addr, 1'b1, `CMD_UTC}; // R03
        else
          tx_next = i_eoc_rx_word; // R01
      end
    end
  end

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      last_rx_reg <= `EOC_TX_RESET;
      verified_reg <= `EOC_TX_RESET;
      same_cnt_reg <= 2'h0;
      data_cnt_reg <= 2'h0;
      eoc_tx_reg <= `EOC_TX_RESET;
      o_eoc_report <= {`EOC_W{1'b0}};
      o_eoc_irq <= 1'b0;
      o_latched_cmds <= {`LATCH_W{1'b0}};
    end
    else
    begin
      o_eoc_irq <= 1'b0;
      if (i_eoc_tx_write)
        eoc_tx_reg <= i_eoc_tx_data; // R08
      if (i_deactivate)
        o_latched_cmds <= {`LATCH_W{1'b0}}; // R04
      if (i_eoc_rx_strobe)
      begin
        last_rx_reg <= i_eoc_rx_word;
        same_cnt_reg <= cnt_next;
        if (triple_ok)
          verified_reg <= i_eoc_rx_word;
        if (auto_mode && addr_ok && !rx_dm)
          data_cnt_reg <= (data_cnt_reg == 2'h3) ? 2'h3 :
            data_cnt_reg + 2'h1;
        else
          data_cnt_reg <= 2'h0;
        case (i_eoc_mode)
          `MODE_AUTO:
          begin
            if (triple_ok)
            begin
              o_eoc_report <= i_eoc_rx_word;
              o_eoc_irq <= 1'b1; // R05
            end
            if (triple_ok && addr_ok && rx_dm && !i_deactivate) // R07
            begin
              case (rx_info)
                `CMD_LOOP_ALL: o_latched_cmds[0] <= 1'b1; // R04
                `CMD_LOOP_B1: o_latched_cmds[1] <= 1'b1;
                `CMD_LOOP_B2: o_latched_cmds[2] <= 1'b1;
                `CMD_CORRUPT: o_latched_cmds[3] <= 1'b1;
                `CMD_NOTIFY: o_latched_cmds[4] <= 1'b1;
                `CMD_RTN:
                begin
                  o_latched_cmds <= {`LATCH_W{1'b0}}; // R21
                  if (!i_eoc_tx_write)
                    eoc_tx_reg <= `EOC_TX_RESET; // R21
                end
                default: o_latched_cmds <= o_latched_cmds;
              endcase
            end
          end
          `MODE_EVERY:
          begin
            o_eoc_report <= i_eoc_rx_word;
            o_eoc_irq <= 1'b1; // R09
          end
          `MODE_CHANGE:
          begin
            if (changed)
            begin
              o_eoc_report <= i_eoc_rx_word;
              o_eoc_irq <= 1'b1; // R12
            end
          end
          default:
          begin
            if (triple_ok)
            begin
              o_eoc_report <= i_eoc_rx_word;
              o_eoc_irq <= 1'b1; // R13
            end
          end
        endcase
      end
    end
  end

  // Two entries absorb a stalled framer for two answers; a further answer is dropped while full
  word_buffer #(
    .W(`EOC_W)
  ) u_tx_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(tx_push),
    .o_in_ready(buf_ready),
    .i_in_data(tx_next),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_word)
  );
  assign o_eoc_tx_full = !buf_ready;

  // ==========================================================
  // M4 filters, one per bit
  // ==========================================================
  reg [M4_W-1:0] m4_prev_reg;
  reg [M4_W-1:0] m4_prev2_reg;
  reg [M4_W-1:0] m4_rep_next;
  reg [2:0] sm_next;
  reg [1:0] sel;
  integer k;

  // Approve a candidate bit by the chosen filter
  function approve;
    input [1:0] mode;
    input cur;
    input p1;
    input p2;
    input crc;
    begin
      case (mode)
        `FILT_CHANGE: approve = 1'b1;
        `FILT_TRIPLE: approve = (cur == p1) && (cur == p2);
        `FILT_CRC: approve = crc;
        default: approve = crc && (cur == p1) && (cur == p2);
      endcase
    end
  endfunction

  always @*
  begin
    m4_rep_next = o_m4_report;
    sm_next = o_sm_bits;
    sel = 2'h0;
    for (k = 0; k < M4_W; k = k + 1)
    begin
      sel = i_m4_filter_sel[2*k +: 2];
      if (approve(sel, i_m4_rx[k], m4_prev_reg[k], m4_prev2_reg[k],
        i_crc_ok)) // R14 R15
        m4_rep_next[k] = i_m4_rx[k];
    end
    for (k = 0; k < 3; k = k + 1)
    begin
      sel = i_sm_same_filter ? i_m4_filter_sel[2*k +: 2] : `FILT_TRIPLE;
      if (approve(sel, i_m4_rx[k], m4_prev_reg[k], m4_prev2_reg[k],
        i_crc_ok)) // R16
        sm_next[k] = i_m4_rx[k];
    end
  end

  // ==========================================================
  // Spare bits
  // ==========================================================
  reg [`SPARE_W-1:0] sp_prev_reg;
  reg [`SPARE_W-1:0] sp_prev2_reg;
  reg [`SPARE_W-1:0] sp_next;
  integer j;

  always @*
  begin
    sp_next = o_spare_report;
    for (j = 0; j < `SPARE_W; j = j + 1)
    begin
      case (i_spare_filter_sel)
        `SPARE_CRC:
          if (i_crc_ok)
            sp_next[j] = i_spare_rx[j]; // R18
        `SPARE_M4:
          if (approve(i_m4_filter_sel[1:0], i_spare_rx[j],
            sp_prev_reg[j], sp_prev2_reg[j], i_crc_ok))
            sp_next[j] = i_spare_rx[j]; // R18
        default: sp_next[j] = i_spare_rx[j];
      endcase
    end
  end

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      m4_prev_reg <= `M4_RESET;
      m4_prev2_reg <= `M4_RESET;
      o_m4_report <= `M4_RESET;
      o_m4_irq <= 1'b0;
      o_sm_bits <= 3'h2; // R17
      sp_prev_reg <= `SPARE_RESET;
      sp_prev2_reg <= `SPARE_RESET;
      o_spare_report <= `SPARE_RESET;
      o_spare_irq <= 1'b0;
      o_spare_tx <= `SPARE_RESET; // R19
    end
    else
    begin
      o_m4_irq <= 1'b0;
      o_spare_irq <= 1'b0;
      if (i_spare_tx_write)
        o_spare_tx <= i_spare_tx_data; // R19
      if (i_deactivate)
        o_sm_bits <= 3'h2; // R17
      if (i_sf_strobe)
      begin
        m4_prev_reg <= i_m4_rx;
        m4_prev2_reg <= m4_prev_reg;
        sp_prev_reg <= i_spare_rx;
        sp_prev2_reg <= sp_prev_reg;
        o_m4_report <= m4_rep_next;
        o_m4_irq <= (m4_rep_next != o_m4_report); // R14
        if (!i_deactivate)
          o_sm_bits <= sm_next;
        o_spare_report <= sp_next;
        o_spare_irq <= (sp_next != o_spare_report);
      end
    end
  end
endmodule

// *** test/eoc_maint_checker.sv ***
// Port-level checker for the EOC and maintenance-bit processor.
// Assumes one clock domain and the header's word layout constants.
`timescale 1ns/1ps
`include "eoc_maint_regs.vh"
module eoc_maint_checker #(
  parameter M4_W = 8
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [1:0] i_eoc_mode,
  input wire i_eoc_rx_strobe,
  input wire [`EOC_W-1:0] i_eoc_rx_word,
  input wire i_sf_strobe,
  input wire i_deactivate,
  input wire i_spare_tx_write,
  input wire [`SPARE_W-1:0] i_spare_tx_data,
  input wire o_tx_valid,
  input wire o_eoc_tx_full,
  input wire [`EOC_W-1:0] o_tx_word,
  input wire [`EOC_W-1:0] o_eoc_report,
  input wire o_eoc_irq,
  input wire [`LATCH_W-1:0] o_latched_cmds,
  input wire o_m4_irq,
  input wire [2:0] o_sm_bits,
  input wire [`SPARE_W-1:0] o_spare_tx,
  input wire [`SPARE_W-1:0] o_spare_report,
  input wire o_spare_irq
);
  wire [7:0] info = i_eoc_rx_word[7:0];
  wire adr = i_eoc_rx_word[11:9] == `ADDR_NT ||
    i_eoc_rx_word[11:9] == `ADDR_BCAST;
  wire defd = info == `CMD_HOLD || info == `CMD_RTN ||
    (info >= `CMD_LOOP_ALL && info <= `CMD_NOTIFY);
  // An empty buffer makes the new answer the head word on the next cycle
  wire auto_rx = i_eoc_rx_strobe && i_eoc_mode == `MODE_AUTO && !o_tx_valid;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  chk_foreign_hold: assert property (auto_rx && !adr |=>
    o_tx_word == {`ADDR_NT, 1'b1, `CMD_HOLD}) else $error("no hold");
  chk_echo_cmd: assert property (auto_rx && adr && i_eoc_rx_word[8] &&
    defd |=> o_tx_word == $past(i_eoc_rx_word)) else $error("no echo");
  chk_undef_utc: assert property (auto_rx && adr && i_eoc_rx_word[8] &&
    !defd && info != `CMD_UTC |=> o_tx_word[7:0] == `CMD_UTC)
    else $error("no unable-to-comply");
  chk_answer_queued: assert property (i_eoc_rx_strobe &&
    !o_eoc_tx_full |=> o_tx_valid) else $error("answer lost");
  chk_every_report: assert property (i_eoc_rx_strobe &&
    i_eoc_mode == `MODE_EVERY |=> o_eoc_irq &&
    o_eoc_report == $past(i_eoc_rx_word)) else $error("no frame report");
  chk_irq_cause: assert property (o_eoc_irq |->
    $past(i_eoc_rx_strobe)) else $error("irq without word");
  chk_no_latch: assert property (i_eoc_mode != `MODE_AUTO &&
    !i_deactivate |=> $stable(o_latched_cmds))
    else $error("latch in transparent");
  chk_deact_clear: assert property (i_deactivate |=>
    o_latched_cmds == 5'h00 && o_sm_bits == 3'h2)
    else $error("deactivate ignored");
  chk_spare_write: assert property (i_spare_tx_write |=>
    o_spare_tx == $past(i_spare_tx_data)) else $error("spare write lost");
  chk_m4_cause: assert property (o_m4_irq |-> $past(i_sf_strobe))
    else $error("m4 irq without frame");
  chk_spare_irq: assert property (i_sf_strobe |=> o_spare_irq ==
    (o_spare_report != $past(o_spare_report)))
    else $error("spare irq wrong");
endmodule

bind eoc_maintenance_bit_processor eoc_maint_checker #(.M4_W(M4_W)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_eoc_mode(i_eoc_mode),
  .i_eoc_rx_strobe(i_eoc_rx_strobe), .i_eoc_rx_word(i_eoc_rx_word),
  .i_sf_strobe(i_sf_strobe), .i_deactivate(i_deactivate),
  .i_spare_tx_write(i_spare_tx_write), .i_spare_tx_data(i_spare_tx_data),
  .o_tx_valid(o_tx_valid), .o_eoc_tx_full(o_eoc_tx_full),
  .o_tx_word(o_tx_word), .o_eoc_report(o_eoc_report), .o_eoc_irq(o_eoc_irq),
  .o_latched_cmds(o_latched_cmds), .o_m4_irq(o_m4_irq),
  .o_sm_bits(o_sm_bits), .o_spare_tx(o_spare_tx),
  .o_spare_report(o_spare_report), .o_spare_irq(o_spare_irq));

// *** test/tx_sink.sv ***
// Framer-side sink for outgoing EOC words.
// Assumes the same clock as the block; a word moves when ready meets valid.
`timescale 1ns/1ps
module tx_sink (
  input wire i_clk,
  input wire i_stall,
  output reg o_ready
);
  reg [1:0] cnt_reg;
  initial
  begin
    cnt_reg = 2'h0;
    o_ready = 1'b0;
  end
  // One idle beat in four keeps the buffer under some back-pressure
  always @(posedge i_clk)
  begin
    cnt_reg <= cnt_reg + 2'h1;
    o_ready <= !i_stall && cnt_reg != 2'h3;
  end
endmodule

// *** test/eoc_maintenance_bit_processor_tb.sv ***
// Self-checking bench for the EOC and maintenance-bit processor.
// Assumes the sink model answers on i_tx_ready and the bound checker.
`timescale 1ns/1ps
module eoc_maintenance_bit_processor_tb;
  reg i_clk, i_resetn, i_eoc_rx_strobe, i_sf_strobe, i_crc_ok, i_deactivate;
  reg i_eoc_tx_write, i_spare_tx_write, stall, sm_same;
  reg [1:0] i_eoc_mode, spare_sel;
  reg [15:0] i_m4_filter_sel;
  reg [11:0] i_eoc_rx_word, i_eoc_tx_data, p1, p2, passed, txreg, w;
  reg [11:0] seq [0:19];
  reg [11:0] q_rep [$];
  reg [11:0] q_tx [$];
  reg [7:0] q_m4 [$];
  reg [7:0] i_m4_rx, m4exp;
  reg [2:0] i_spare_rx, i_spare_tx_data;
  reg [4:0] lat;
  wire i_tx_ready, o_tx_valid, o_eoc_tx_full, o_eoc_irq, o_m4_irq;
  wire [11:0] o_tx_word, o_eoc_report;
  wire [4:0] o_latched_cmds;
  wire [7:0] o_m4_report;
  wire [2:0] o_sm_bits, o_spare_tx, o_spare_report;
  integer fails, checks, cyc, zeros, k;
  eoc_maintenance_bit_processor #(.M4_W(8)) DUT (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_eoc_mode(i_eoc_mode),
    .i_m4_filter_sel(i_m4_filter_sel), .i_sm_same_filter(sm_same),
    .i_spare_filter_sel(spare_sel), .i_eoc_rx_strobe(i_eoc_rx_strobe),
    .i_eoc_rx_word(i_eoc_rx_word), .i_sf_strobe(i_sf_strobe),
    .i_crc_ok(i_crc_ok), .i_m4_rx(i_m4_rx), .i_spare_rx(i_spare_rx),
    .i_deactivate(i_deactivate), .i_eoc_tx_write(i_eoc_tx_write),
    .i_eoc_tx_data(i_eoc_tx_data), .i_spare_tx_write(i_spare_tx_write),
    .i_spare_tx_data(i_spare_tx_data), .i_tx_ready(i_tx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_word(o_tx_word),
    .o_eoc_tx_full(o_eoc_tx_full), .o_eoc_report(o_eoc_report),
    .o_eoc_irq(o_eoc_irq), .o_latched_cmds(o_latched_cmds),
    .o_m4_report(o_m4_report), .o_m4_irq(o_m4_irq), .o_sm_bits(o_sm_bits),
    .o_spare_report(o_spare_report), .o_spare_irq(), .o_spare_tx(o_spare_tx));
  tx_sink u_sink (.i_clk(i_clk), .i_stall(stall), .o_ready(i_tx_ready));
  task check(input string name, input [11:0] exp, input [11:0] seen);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task close_out;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // ==========================================
  // Stimulus tasks, each noting what it expects
  task rx(input [11:0] wd);
    reg pass, adr, lt;
  begin
    @(posedge i_clk);
    i_eoc_rx_strobe <= 1'b1;
    i_eoc_rx_word <= wd;
    // Judge fullness after the edge that launched the strobe
    @(negedge i_clk);
    adr = wd[11:9] == 3'h0 || wd[11:9] == 3'h7;
    pass = wd == p1 && wd == p2 && wd != passed;
    if (pass)
      passed = wd;
    if (i_eoc_mode == 2'h1 || (i_eoc_mode == 2'h2 && wd != p1) ||
        (i_eoc_mode[0] == i_eoc_mode[1] && pass))
      q_rep.push_back(wd);
    zeros = (adr && !wd[8] && i_eoc_mode == 2'h0) ? zeros + 1 : 0;
    if (i_eoc_mode != 2'h0)
      w = txreg;
    else if (!adr)
      w = 12'h100;
    else if (zeros >= 3 || (wd[8] && !(wd[7:0] == 8'h00 ||
        wd[7:0] == 8'hFF || (wd[7:4] == 4'h5 && wd[3:0] < 4'h5))))
      w = {wd[11:9], 9'h1AA};
    else
      w = wd;
    lt = i_eoc_mode == 2'h0 && pass && adr && wd[8];
    if (lt && wd[7:0] == 8'hFF)
      lat = 5'h00;
    if (lt && wd[7:0] == 8'hFF)
      txreg = 12'h0FF;
    if (lt && wd[7:4] == 4'h5 && wd[3:0] < 4'h5)
      lat[wd[2:0]] = 1'b1;
    // A full buffer refuses the answer, so nothing is expected on the wire
    if (!o_eoc_tx_full)
      q_tx.push_back(w);
    p2 = p1;
    p1 = wd;
    @(posedge i_clk);
    i_eoc_rx_strobe <= 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check("latched", lat, o_latched_cmds);
  end
  endtask
  task sf(input [7:0] m, input c, input [7:0] e);
  begin
    if (e != m4exp)
      q_m4.push_back(e);
    m4exp = e;
    @(posedge i_clk);
    i_sf_strobe <= 1'b1;
    i_m4_rx <= m;
    i_spare_rx <= m[2:0];
    i_crc_ok <= c;
    @(posedge i_clk);
    i_sf_strobe <= 1'b0;
    repeat (2) @(posedge i_clk);
  end
  endtask
  // ==========================================
  // Monitors and the hang guard
  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (o_eoc_irq === 1'b1)
      if (q_rep.size() == 0) check("extra irq", 12'h000, 12'h001);
      else check("report", q_rep.pop_front(), o_eoc_report);
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1)
      if (q_tx.size() == 0) check("extra tx", 12'h000, 12'h001);
      else check("tx word", q_tx.pop_front(), o_tx_word);
    if (o_m4_irq === 1'b1)
      if (q_m4.size() == 0) check("extra m4", 12'h000, 12'h001);
      else check("m4 report", q_m4.pop_front(), o_m4_report);
    if (cyc == 5000)
    begin
      fails = fails + 1;
      close_out;
    end
  end
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {i_resetn, i_eoc_rx_strobe, i_sf_strobe, i_crc_ok, i_deactivate} = 5'h00;
    {i_eoc_tx_write, i_spare_tx_write, stall, i_eoc_mode} = 5'h00;
    {sm_same, spare_sel} = 3'h2;
    {i_m4_filter_sel, i_eoc_rx_word, i_eoc_tx_data} = 40'h0;
    {i_m4_rx, i_spare_rx, i_spare_tx_data, lat} = 19'h0;
    {p1, p2, passed, txreg} = {4{12'h0FF}};
    {fails, checks, cyc, zeros} = 128'h0;
    m4exp = 8'h02;
    k = $urandom(66615);
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    check("sm bits", 3'h2, o_sm_bits);
    check("spare tx", 3'h7, o_spare_tx);
    seq = '{12'h150, 12'h150, 12'h150, 12'hF53, 12'hF53, 12'hF53, 12'h550,
      12'h550, 12'h550, 12'h012, 12'h012, 12'h012, 12'h012, 12'h133, 12'h1FF,
      12'h1FF, 12'h1FF, 12'h151, 12'h151, 12'h151};
    for (k = 0; k < 20; k = k + 1)
      rx(seq[k]);
    @(posedge i_clk);
    i_deactivate <= 1'b1;
    @(posedge i_clk);
    i_deactivate <= 1'b0;
    lat = 5'h00;
    @(negedge i_clk);
    check("sm bits", 3'h2, o_sm_bits);
    @(posedge i_clk);
    i_eoc_mode <= 2'h1;
    rx(12'h2C3);
    @(posedge i_clk);
    i_eoc_tx_data <= $urandom & 12'hFFF;
    i_eoc_tx_write <= 1'b1;
    @(posedge i_clk);
    txreg = i_eoc_tx_data;
    i_eoc_tx_write <= 1'b0;
    repeat (5) rx($urandom & 12'hFFF);
    stall <= 1'b1;
    repeat (3) rx($urandom & 12'hFFF);
    check("tx full", 1'b1, o_eoc_tx_full);
    stall <= 1'b0;
    seq = '{12'h1A0, 12'h1A0, 12'h1B0, 12'h1B0, 12'h1A0, 12'h1C0, 12'h1C0,
      12'h1C0, 12'h1C0, 12'h150, 12'h150, 12'h1B0, 12'h150, 12'h150, 12'h150,
      12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    for (k = 0; k < 15; k = k + 1)
    begin
      if (k == 0 || k == 5)
      begin
        @(posedge i_clk);
        i_eoc_mode <= (k == 0) ? 2'h2 : 2'h3;
      end
      rx(seq[k]);
    end
    @(posedge i_clk);
    i_spare_tx_data <= 3'h5;
    i_spare_tx_write <= 1'b1;
    @(posedge i_clk);
    i_spare_tx_write <= 1'b0;
    @(negedge i_clk);
    check("spare tx", 3'h5, o_spare_tx);
    sf(8'h5A, 1'b1, 8'h5A);
    i_m4_filter_sel <= 16'h5555;
    sf(8'h33, 1'b1, 8'h5A);
    sf(8'h33, 1'b1, 8'h5A);
    sf(8'h33, 1'b1, 8'h33);
    @(negedge i_clk);
    check("sm bits", 3'h3, o_sm_bits);
    i_m4_filter_sel <= 16'hAAAA;
    spare_sel <= 2'h1;
    sm_same <= 1'b1;
    sf(8'h0F, 1'b0, 8'h33);
    @(negedge i_clk);
    check("spare rep", 3'h3, o_spare_report);
    check("sm bits", 3'h3, o_sm_bits);
    sf(8'h0F, 1'b1, 8'h0F);
    @(negedge i_clk);
    check("spare rep", 3'h7, o_spare_report);
    check("sm bits", 3'h7, o_sm_bits);
    @(posedge i_clk);
    spare_sel <= 2'h0;
    sf(8'h0C, 1'b0, 8'h0F);
    @(negedge i_clk);
    check("spare rep", 3'h7, o_spare_report);
    repeat (10) @(posedge i_clk);
    check("pending", 12'h000,
      12'(q_rep.size() + q_tx.size() + q_m4.size()));
    close_out;
  end
endmodule
